// >>> dos_pkg.sv
// Purpose: Shared constants and types for the differential output selector.
// Assumes: A 100 MHz system clock.
// Notes:   Mode codes are two's complement bytes.
package dos_pkg;

  localparam logic [7:0]  MODE_DISABLED   = 8'hFF;
  localparam logic [7:0]  MODE_QUADRATURE = 8'h00;
  localparam logic [7:0]  MODE_IO_STATUS  = 8'h08;
  localparam logic [7:0]  MODE_RESET      = MODE_QUADRATURE;

  localparam logic [7:0]  SIG_CONST_OFF   = 8'h80;
  localparam logic [7:0]  SEL_RESET       = SIG_CONST_OFF;
  localparam logic        INV_RESET       = 1'b0;
  localparam logic [7:0]  DELAY_MS_RESET  = 8'h00;
  localparam logic [7:0]  DELAY_MS_MAX    = 8'hFA;
  localparam int          SIG_COUNT       = 256;

  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          MS_IN_NS        = 1000000;
  localparam int          CYCLES_PER_MS   = MS_IN_NS / CLK_PERIOD_NS;

  localparam logic [15:0] ENC_CPR_DEFAULT = 16'h2710;
  localparam logic [31:0] POS_STEP_FWD    = 32'h00000001;
  localparam logic [31:0] POS_STEP_REV    = 32'hFFFFFFFF;

  typedef enum logic [3:0] {
    DOS_Q00 = 4'b0001,
    DOS_Q10 = 4'b0010,
    DOS_Q11 = 4'b0100,
    DOS_Q01 = 4'b1000
  } dos_quad_t;

endpackage

// >>> dos_channel.sv
// Purpose: One differential channel in I/O status mode: select, invert, OFF delay.
// Assumes: Internal signals come from logic on the same clock.
// Notes:   Held in its idle state whenever i_enable is low.
`timescale 1ns/10ps
`default_nettype none
module dos_channel
  import dos_pkg::*;
#(
  parameter int P_CYCLES_PER_MS = CYCLES_PER_MS
)(
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  input  wire logic                 i_enable,
  input  wire logic [SIG_COUNT-1:0] i_signals,
  input  wire logic [7:0]           i_select,
  input  wire logic                 i_invert,
  input  wire logic [7:0]           i_delay_ms,
  output logic                      o_level
);

  localparam int W = $clog2(P_CYCLES_PER_MS + 1);

  typedef struct packed {
    logic         level;
    logic [7:0]   ms_left;
    logic [W-1:0] tick;
  } dos_chan_t;

  localparam dos_chan_t CHAN_RESET = '{level: 1'b0, ms_left: 8'h00, tick: '0};

  dos_chan_t q;
  dos_chan_t d;
  logic      src;
  logic      on;

  always_comb
  begin
    d   = q;
    src = i_signals[i_select] & (i_select != SIG_CONST_OFF);
    on  = src ^ i_invert;
    if (!i_enable)
    begin
      d = CHAN_RESET;
    end
    else if (on)
    begin
      d.level   = 1'b1;
      d.ms_left = (i_delay_ms > DELAY_MS_MAX) ? DELAY_MS_MAX : i_delay_ms;
      d.tick    = '0;
    end
    else if (q.level)
    begin
      // The output stays ON until the programmed milliseconds have elapsed.
      if (q.ms_left == 8'h00)
      begin
        d.level = 1'b0;
      end
      else if (q.tick == W'(P_CYCLES_PER_MS - 1))
      begin
        d.tick    = '0;
        d.ms_left = q.ms_left - 8'h01;
      end
      else
      begin
        d.tick = q.tick + W'(1);
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      q <= CHAN_RESET;
    else
      q <= d;
  end

  assign o_level = q.level;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_on_then_off;
    (i_enable && on) ##1 (i_enable && !on && q.ms_left != 8'h00);
  endsequence

  a_on_drives_high: assert property ((i_enable && on) |=> o_level)
    else $error("Channel did not turn ON with its active source.");

  // A latched non-zero delay must keep the output ON past the first OFF cycle.
  a_off_delay_hold: assert property (s_on_then_off |=> o_level)
    else $error("Channel dropped before its OFF delay ran.");

  a_zero_delay_off: assert property (
    (i_enable && !on && o_level && q.ms_left == 8'h00) |=> !o_level)
    else $error("Channel with expired delay stayed ON.");

  a_const_off_low: assert property (
    (i_enable && i_select == SIG_CONST_OFF && !i_invert && !o_level) |=> !o_level)
    else $error("Constant-off selection turned the channel ON.");

endmodule
`default_nettype wire

// >>> dos_top.sv
// Purpose: Drives the two differential output channels from a mode setting.
// Assumes: Feedback position moves by at most one count per clock; resolution
//          does not exceed P_ENC_CPR; all inputs come from logic on this clock.
// Notes:   Quadrature edges are scaled from encoder counts by accumulation.
// Notes on behaviour
// - Mode picks off, quadrature, or I/O status.
// - Selection, invert, delay only used in I/O mode.
// - Each channel carries its chosen signal, default off.
// - Per-channel polarity: pass or invert.
// - OFF delay holds output 0 to 250 ms.
// - Quadrature phase order shows direction of motion.
// - Pulses follow motor motion for outside counting.
// - Resolution taken at power-on.
// - Resolution follows later changes.
`timescale 1ns/10ps
`default_nettype none
module dos_top
  import dos_pkg::*;
#(
  parameter int          P_CYCLES_PER_MS = CYCLES_PER_MS,
  parameter logic [15:0] P_ENC_CPR       = ENC_CPR_DEFAULT
)(
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  input  wire logic [7:0]           i_mode,
  input  wire logic [31:0]          i_fb_position,
  input  wire logic [15:0]          i_motor_resolution,
  input  wire logic [SIG_COUNT-1:0] i_io_signals,
  input  wire logic [7:0]           i_sel_a,
  input  wire logic [7:0]           i_sel_b,
  input  wire logic                 i_invert_a,
  input  wire logic                 i_invert_b,
  input  wire logic [7:0]           i_delay_ms_a,
  input  wire logic [7:0]           i_delay_ms_b,
  output logic                      o_diff_channel_a,
  output logic                      o_diff_channel_b
);

  typedef struct packed {
    logic        started;
    logic [31:0] fb_prev;
    logic [15:0] res;
    logic [15:0] acc;
    dos_quad_t   quad;
    logic        out_a;
    logic        out_b;
  } dos_state_t;

  localparam dos_state_t STATE_RESET = '{
    started: 1'b0,
    fb_prev: 32'h00000000,
    res:     16'h0000,
    acc:     16'h0000,
    quad:    DOS_Q00,
    out_a:   1'b0,
    out_b:   1'b0
  };

  dos_state_t  q;
  dos_state_t  d;
  logic [31:0] pos_delta;
  logic [16:0] acc_up;
  logic        emit_fwd;
  logic        emit_rev;
  logic        quad_phase_a;
  logic        quad_phase_b;
  logic        io_enable;
  logic        chan_a_level;
  logic        chan_b_level;

  assign io_enable = (i_mode == MODE_IO_STATUS);

  dos_channel #(
    .P_CYCLES_PER_MS (P_CYCLES_PER_MS)
  ) u_chan_a (
    .i_clock    (i_clock),
    .i_rst      (i_rst),
    .i_enable   (io_enable),
    .i_signals  (i_io_signals),
    .i_select   (i_sel_a),
    .i_invert   (i_invert_a),
    .i_delay_ms (i_delay_ms_a),
    .o_level    (chan_a_level)
  );

  dos_channel #(
    .P_CYCLES_PER_MS (P_CYCLES_PER_MS)
  ) u_chan_b (
    .i_clock    (i_clock),
    .i_rst      (i_rst),
    .i_enable   (io_enable),
    .i_signals  (i_io_signals),
    .i_select   (i_sel_b),
    .i_invert   (i_invert_b),
    .i_delay_ms (i_delay_ms_b),
    .o_level    (chan_b_level)
  );

  always_comb
  begin
    quad_phase_a = (q.quad == DOS_Q10) || (q.quad == DOS_Q11);
    quad_phase_b = (q.quad == DOS_Q11) || (q.quad == DOS_Q01);
  end

  always_comb
  begin
    d         = q;
    emit_fwd  = 1'b0;
    emit_rev  = 1'b0;
    pos_delta = i_fb_position - q.fb_prev;
    acc_up    = {1'b0, q.acc} + {1'b0, q.res};
    d.fb_prev = i_fb_position;
    d.res     = i_motor_resolution;
    if (!q.started)
    begin
      // First cycle after reset only captures position and resolution.
      d.started = 1'b1;
      d.acc     = 16'h0000;
    end
    else if (pos_delta == POS_STEP_FWD)
    begin
      // Each encoder count adds res/CPR of an output step.
      if (acc_up >= {1'b0, P_ENC_CPR})
      begin
        d.acc    = 16'(acc_up - {1'b0, P_ENC_CPR});
        emit_fwd = 1'b1;
      end
      else
      begin
        d.acc = acc_up[15:0];
      end
    end
    else if (pos_delta == POS_STEP_REV)
    begin
      if (q.acc < q.res)
      begin
        d.acc    = 16'(({1'b0, q.acc} + {1'b0, P_ENC_CPR}) - {1'b0, q.res});
        emit_rev = 1'b1;
      end
      else
      begin
        d.acc = q.acc - q.res;
      end
    end

    // Forward walks 00,10,11,01 so phase A leads; reverse walks back.
    if (emit_fwd)
    begin
      case (q.quad)
        DOS_Q00: d.quad = DOS_Q10;
        DOS_Q10: d.quad = DOS_Q11;
        DOS_Q11: d.quad = DOS_Q01;
        DOS_Q01: d.quad = DOS_Q00;
        default: d.quad = DOS_Q00;
      endcase
    end
    else if (emit_rev)
    begin
      case (q.quad)
        DOS_Q00: d.quad = DOS_Q01;
        DOS_Q01: d.quad = DOS_Q11;
        DOS_Q11: d.quad = DOS_Q10;
        DOS_Q10: d.quad = DOS_Q00;
        default: d.quad = DOS_Q00;
      endcase
    end

    case (i_mode)
      MODE_QUADRATURE:
      begin
        d.out_a = quad_phase_a;
        d.out_b = quad_phase_b;
      end
      MODE_IO_STATUS:
      begin
        d.out_a = chan_a_level;
        d.out_b = chan_b_level;
      end
      default:
      begin
        d.out_a = 1'b0;
        d.out_b = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      q <= STATE_RESET;
    else
      q <= d;
  end

  assign o_diff_channel_a = q.out_a;
  assign o_diff_channel_b = q.out_b;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_fwd_from_zero;
    emit_fwd && q.quad == DOS_Q00;
  endsequence

  sequence s_rev_from_zero;
    emit_rev && q.quad == DOS_Q00;
  endsequence

  a_disabled_low: assert property (
    (i_mode == MODE_DISABLED) [*2] |-> !o_diff_channel_a && !o_diff_channel_b)
    else $error("Disabled mode left a channel high.");

  a_quad_to_pins: assert property (
    (i_mode == MODE_QUADRATURE) |=> o_diff_channel_a == $past(quad_phase_a)
                                    && o_diff_channel_b == $past(quad_phase_b))
    else $error("Quadrature mode did not route the phases.");

  a_fwd_a_leads: assert property (s_fwd_from_zero |=> quad_phase_a && !quad_phase_b)
    else $error("Forward step did not move phase A first.");

  a_rev_b_leads: assert property (s_rev_from_zero |=> !quad_phase_a && quad_phase_b)
    else $error("Reverse step did not move phase B first.");

  a_single_edge: assert property (
    $changed(q.quad) |-> ($changed(quad_phase_a) != $changed(quad_phase_b)))
    else $error("Quadrature step changed both or no phases.");

  a_no_move_hold: assert property (
    (q.started && pos_delta == 32'h00000000) |=> $stable(q.quad))
    else $error("Quadrature changed without feedback motion.");

  a_res_powerup: assert property (!q.started |=> q.res == $past(i_motor_resolution))
    else $error("Resolution was not taken at start.");

  a_res_follows: assert property (
    (q.started && i_motor_resolution != q.res) |=> q.res == $past(i_motor_resolution))
    else $error("Resolution change was not followed.");

  a_io_ignored: assert property ((i_mode != MODE_IO_STATUS) |=> !chan_a_level && !chan_b_level)
    else $error("Channel logic active outside I/O mode.");

endmodule
`default_nettype wire

// >>> dos_counter_model.sv
// Purpose: Outside counter that tracks position from the two channels.
// Assumes: The channels move at most one phase step per clock.
// Notes:   A jump of two phase steps gives no direction and is not counted.
`timescale 1ns/10ps
`default_nettype none
module dos_counter_model (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_phase_a,
  input  wire logic        i_phase_b,
  output logic      [31:0] o_count
);
  logic [1:0] idx_d;
  logic [1:0] idx_q;
  assign idx_d = {i_phase_b, i_phase_a ^ i_phase_b};
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      idx_q   <= 2'h0;
      o_count <= 32'h0;
    end
    else
    begin
      idx_q <= idx_d;
      if (idx_d - idx_q == 2'h1)
        o_count <= o_count + 32'h1;
      else if (idx_d - idx_q == 2'h3)
        o_count <= o_count - 32'h1;
    end
  end
endmodule
`default_nettype wire

// >>> dos_top_tb.sv
// Purpose: Self-checking bench for the differential output selector.
// Assumes: 4 clocks stand for 1 ms; 8 encoder counts per revolution.
// Notes:   Table rows cover the level modes; quadrature is hand-written.
`timescale 1ns/10ps
`default_nettype none
module dos_top_tb
  import dos_pkg::*;
;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] sel_a;
    logic       inv_a;
    logic [7:0] sel_b;
    logic       inv_b;
    logic       exp_a;
    logic       exp_b;
  } dos_row_t;
  logic                 i_clock  = 1'b0;
  logic                 i_rst    = 1'b1;
  logic [7:0]           mode     = MODE_QUADRATURE;
  logic [31:0]          pos      = 32'h0;
  logic [15:0]          res      = 16'h0008;
  logic [SIG_COUNT-1:0] sigs     = 256'h0;
  logic [7:0]           sel_a    = SEL_RESET;
  logic [7:0]           sel_b    = SEL_RESET;
  logic                 inv_a    = INV_RESET;
  logic                 inv_b    = INV_RESET;
  logic [7:0]           dly_a    = DELAY_MS_RESET;
  logic [7:0]           dly_b    = DELAY_MS_RESET;
  logic                 out_a;
  logic                 out_b;
  logic [31:0]          count;
  int                   fails    = 0;
  int                   compares = 0;
  int                   cycles   = 0;
  dos_row_t             rows [6];

  dos_top #(.P_CYCLES_PER_MS(4), .P_ENC_CPR(16'h0008)) DUT (
    .i_clock(i_clock), .i_rst(i_rst), .i_mode(mode), .i_fb_position(pos),
    .i_motor_resolution(res), .i_io_signals(sigs), .i_sel_a(sel_a), .i_sel_b(sel_b),
    .i_invert_a(inv_a), .i_invert_b(inv_b), .i_delay_ms_a(dly_a), .i_delay_ms_b(dly_b),
    .o_diff_channel_a(out_a), .o_diff_channel_b(out_b));
  dos_counter_model u_counter (
    .i_clock(i_clock), .i_rst(i_rst), .i_phase_a(out_a), .i_phase_b(out_b),
    .o_count(count));

  always #5 i_clock = ~i_clock;

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // One count every two clocks, then time for the pins and the counter.
  task automatic move(input int n, input logic [31:0] step);
    repeat (n)
    begin
      pos = pos + step;
      cyc(2);
    end
    cyc(4);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      fails++;
      $display("MISMATCH timeout expected 0 seen 1");
      tally_and_finish();
    end
  end

  initial
  begin
    rows = '{
      '{MODE_IO_STATUS, 8'h05, 1'b0, 8'h06, 1'b0, 1'b1, 1'b0},
      '{MODE_IO_STATUS, 8'h05, 1'b1, 8'h06, 1'b1, 1'b0, 1'b1},
      '{MODE_DISABLED,  8'h05, 1'b0, 8'h06, 1'b1, 1'b0, 1'b0},
      '{MODE_IO_STATUS, 8'h80, 1'b0, 8'h80, 1'b1, 1'b0, 1'b1},
      '{8'h01,          8'h05, 1'b0, 8'h05, 1'b0, 1'b0, 1'b0},
      '{MODE_IO_STATUS, 8'h06, 1'b0, 8'h05, 1'b0, 1'b0, 1'b1}};
    sigs[5]   = 1'b1;
    sigs[128] = 1'b1;
    cyc(5);
    i_rst = 1'b0;
    cyc(2);
    check("idle a", 1'b0, out_a);
    check("idle b", 1'b0, out_b);
    foreach (rows[i])
    begin
      mode  = rows[i].mode;
      sel_a = rows[i].sel_a;
      inv_a = rows[i].inv_a;
      sel_b = rows[i].sel_b;
      inv_b = rows[i].inv_b;
      cyc(5);
      check("row a", rows[i].exp_a, out_a);
      check("row b", rows[i].exp_b, out_b);
    end
    $display("test table done");
    sel_a = 8'h05;
    inv_a = 1'b0;
    dly_a = 8'h01;
    cyc(4);
    check("delay on", 1'b1, out_a);
    sigs[5] = 1'b0;
    cyc(3);
    check("delay hold", 1'b1, out_a);
    cyc(2);
    check("delay last", 1'b1, out_a);
    cyc(1);
    check("delay off", 1'b0, out_a);
    $display("test off delay done");
    sigs[5] = 1'b1;
    inv_a   = 1'b1;
    mode    = MODE_QUADRATURE;
    i_rst   = 1'b1;
    cyc(1);
    check("reset a", 1'b0, out_a);
    check("reset b", 1'b0, out_b);
    cyc(2);
    i_rst = 1'b0;
    cyc(2);
    $display("test reset done");
    move(1, POS_STEP_FWD);
    check("lead a", 1'b1, out_a);
    check("lead b", 1'b0, out_b);
    move(7, POS_STEP_FWD);
    check("fwd count", 32'h8, count);
    move(3, POS_STEP_REV);
    check("rev count", 32'h5, count);
    res = 16'h0004;
    cyc(2);
    move(8, POS_STEP_FWD);
    check("half res count", 32'h9, count);
    $display("test quadrature done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
